// file: logic/tif_pkg.sv
// Purpose: Shared constants and carriers for the transmit flag block
// Assumes: 32-bit APB register bus, byte addresses
// Notes: Offsets are word aligned
package tif_pkg;
	// Register byte offsets
	localparam logic [7:0] TIF_OFF_FLAGS = 8'h00;
	localparam logic [7:0] TIF_OFF_SUMMARY = 8'h04;
	localparam logic [7:0] TIF_OFF_ENABLES = 8'h08;
	localparam logic [7:0] TIF_OFF_EVT_STATUS = 8'h0c;
	localparam logic [7:0] TIF_OFF_EVT_CLEAR = 8'h10;
	// Field positions in flag, enable and event registers
	localparam int TIF_BIT_WARN = 9;
	localparam int TIF_BIT_UPD = 8;
	localparam int TIF_NUM_Q = 4;
	// Field positions in the summary register
	localparam int TIF_SUM_DESC_LO = 17;
	localparam int TIF_SUM_PTP = 13;
	localparam int TIF_SUM_RXWARN = 12;
	localparam int TIF_SUM_WARN = 9;
	localparam int TIF_SUM_UPD = 8;
	localparam int TIF_SUM_MAC = 7;
	localparam int TIF_SUM_ERR = 6;
	// Implemented bits of the flag layout, rest read as zero
	localparam logic [31:0] TIF_FLAG_MASK = 32'h0000_030f;
	localparam logic [31:0] TIF_RESET_WORD = 32'h0000_0000;
	// One finished frame from the transmit path
	typedef struct packed {
		logic done;
		logic [1:0] queue;
		logic tstamp_req;
	} tif_txdone_s;
	// Descriptor interrupt enables and flags, index 0 unused
	typedef struct packed {
		logic [15:0] enable;
		logic [15:0] flag;
	} tif_desc_s;
endpackage : tif_pkg

// file: logic/tif_top.sv
// Purpose: Transmit interrupt flags, summary status and APB access
// Assumes: All event inputs come from logic on pclk
// Notes: One wait state on every APB access
// Functional notes
// - Warn flag cleared outside operation or FIFO disabled
// - Warn flag set on stamped frame, one entry held
// - Update flag cleared: not operating, disabled, release
// - Release write of one clears update flag
// - Update flag set on stamped frame when enabled
// - Stamp flags cleared only by writing zero
// - Queue flag set when queue frame sent
// - Queue flags cleared when leaving operation mode
// - Queue flags cleared only by writing zero
// - Queue flag marks frame end, not descriptor
// - Reserved flag bits read as zero
// - Descriptor summary is enable AND flag
// - Interrupt while queue enable and flag set
// - Receive warn summary is enable AND flag
// - MAC summary follows MAC core interrupt
// - Error summary when any enabled error bit is set
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module tif_top #(
	parameter int ERR_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_mode,
	input wire logic tstamp_fifo_enable,
	input wire logic tstamp_fifo_release,
	input wire logic tstamp_fifo_one_held,
	input wire tif_pkg::tif_txdone_s tx_done,
	input wire tif_pkg::tif_desc_s desc_irq,
	input wire logic rx_fifo_warn_enable,
	input wire logic rx_fifo_warn_flag,
	input wire logic mac_irq,
	input wire logic ptp_irq_summary,
	input wire logic [ERR_W-1:0] error_flag_reg,
	input wire logic [ERR_W-1:0] error_enable_reg,
	output logic irq
);
	import tif_pkg::*;

	// Elaboration check on widths
	if (ERR_W < 1 || ERR_W > 32)
	begin : g_bad_err_w
		$error("ERR_W must lie between 1 and 32");
	end

	logic tstamp_fifo_warn_flag;
	logic tstamp_fifo_update_flag;
	logic [TIF_NUM_Q-1:0] frame_sent_flag;
	logic [31:0] tx_irq_enables;
	logic [31:0] evt_status;
	logic op_mode_q;
	logic leave_op;
	logic stamped_done;
	logic warn_set;
	logic upd_set;
	logic [TIF_NUM_Q-1:0] fs_set;
	logic wr_en;
	logic rd_en;
	logic wr_flags;
	logic [31:0] flags_word;
	logic [31:0] irq_summary_status;
	logic [31:0] evt_set;
	logic [15:0] desc_sum;
	logic mapped;

	// Access phase completes on the cycle pready is high
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && penable && !pready && !pwrite;
	assign wr_flags = wr_en && (paddr == TIF_OFF_FLAGS);
	assign mapped = (paddr == TIF_OFF_FLAGS) || (paddr == TIF_OFF_SUMMARY) ||
		(paddr == TIF_OFF_ENABLES) || (paddr == TIF_OFF_EVT_STATUS) ||
		(paddr == TIF_OFF_EVT_CLEAR);

	// Operation mode exit detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			op_mode_q <= 1'b0;
		else
			op_mode_q <= op_mode;
	end
	assign leave_op = op_mode_q && !op_mode;

	// Hardware set events
	assign stamped_done = tx_done.done && tx_done.tstamp_req;
	assign warn_set = stamped_done && tstamp_fifo_one_held;
	assign upd_set = stamped_done && tstamp_fifo_enable;

	// Warning flag: mode clear beats set, set beats software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tstamp_fifo_warn_flag <= 1'b0;
		else if (!op_mode || !tstamp_fifo_enable)
			tstamp_fifo_warn_flag <= 1'b0;
		else if (warn_set)
			tstamp_fifo_warn_flag <= 1'b1;
		else if (wr_flags && !pwdata[TIF_BIT_WARN])
			tstamp_fifo_warn_flag <= 1'b0;
	end

	// Update flag: release write and zero write lose to a set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tstamp_fifo_update_flag <= 1'b0;
		else if (!op_mode || !tstamp_fifo_enable)
			tstamp_fifo_update_flag <= 1'b0;
		else if (upd_set)
			tstamp_fifo_update_flag <= 1'b1;
		else if (tstamp_fifo_release)
			tstamp_fifo_update_flag <= 1'b0;
		else if (wr_flags && !pwdata[TIF_BIT_UPD])
			tstamp_fifo_update_flag <= 1'b0;
	end

	// Per-queue frame-sent flags, set at MAC frame end only
	for (genvar q = 0; q < TIF_NUM_Q; q++)
	begin : g_queue
		assign fs_set[q] = tx_done.done && (tx_done.queue == 2'(q));
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				frame_sent_flag[q] <= 1'b0;
			else if (leave_op)
				frame_sent_flag[q] <= 1'b0;
			else if (fs_set[q])
				frame_sent_flag[q] <= 1'b1;
			else if (wr_flags && !pwdata[q])
				frame_sent_flag[q] <= 1'b0;
		end
	end

	// Flag word with reserved bits forced low
	always_comb
	begin
		flags_word = TIF_RESET_WORD;
		flags_word[TIF_BIT_WARN] = tstamp_fifo_warn_flag;
		flags_word[TIF_BIT_UPD] = tstamp_fifo_update_flag;
		flags_word[TIF_NUM_Q-1:0] = frame_sent_flag;
		flags_word = flags_word & TIF_FLAG_MASK;
	end

	// Summary word, computed from sources only
	assign desc_sum = desc_irq.enable & desc_irq.flag;
	always_comb
	begin
		irq_summary_status = TIF_RESET_WORD;
		irq_summary_status[31:TIF_SUM_DESC_LO] = desc_sum[15:1];
		irq_summary_status[TIF_SUM_PTP] = ptp_irq_summary;
		irq_summary_status[TIF_SUM_RXWARN] = rx_fifo_warn_enable && rx_fifo_warn_flag;
		irq_summary_status[TIF_SUM_WARN] =
			tx_irq_enables[TIF_BIT_WARN] && tstamp_fifo_warn_flag;
		irq_summary_status[TIF_SUM_UPD] =
			tx_irq_enables[TIF_BIT_UPD] && tstamp_fifo_update_flag;
		irq_summary_status[TIF_SUM_MAC] = mac_irq;
		irq_summary_status[TIF_SUM_ERR] = |(error_flag_reg & error_enable_reg);
	end

	// Enable register, same layout as the flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_irq_enables <= TIF_RESET_WORD;
		else if (wr_en && paddr == TIF_OFF_ENABLES)
			tx_irq_enables <= pwdata & TIF_FLAG_MASK;
	end

	// Sticky event record, set wins over write-one clear
	always_comb
	begin
		evt_set = TIF_RESET_WORD;
		evt_set[TIF_BIT_WARN] = warn_set && op_mode && tstamp_fifo_enable;
		evt_set[TIF_BIT_UPD] = upd_set && op_mode;
		evt_set[TIF_NUM_Q-1:0] = leave_op ? '0 : fs_set;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			evt_status <= TIF_RESET_WORD;
		else if (wr_en && paddr == TIF_OFF_EVT_CLEAR)
			evt_status <= (evt_status & ~pwdata) | evt_set;
		else
			evt_status <= evt_status | evt_set;
	end

	// Interrupt line from enabled flags and events
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |((flags_word | evt_status) & tx_irq_enables);
	end

	// APB answer: one wait state, data and error with pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= TIF_RESET_WORD;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (rd_en)
			begin
				case (paddr)
					TIF_OFF_FLAGS: prdata <= flags_word;
					TIF_OFF_SUMMARY: prdata <= irq_summary_status;
					TIF_OFF_ENABLES: prdata <= tx_irq_enables;
					TIF_OFF_EVT_STATUS: prdata <= evt_status;
					default: prdata <= TIF_RESET_WORD;
				endcase
			end
			else
				prdata <= TIF_RESET_WORD;
		end
	end

	// Checks on flag behaviour
	property p_warn_clr;
		@(posedge pclk) disable iff (!presetn)
		(!op_mode || !tstamp_fifo_enable) |=> !tstamp_fifo_warn_flag;
	endproperty
	a_warn_clr: assert property (p_warn_clr) else $error("warn flag not cleared");

	property p_warn_set;
		@(posedge pclk) disable iff (!presetn)
		(warn_set && op_mode && tstamp_fifo_enable) |=> tstamp_fifo_warn_flag;
	endproperty
	a_warn_set: assert property (p_warn_set) else $error("warn flag not set");

	property p_upd_mode_clr;
		@(posedge pclk) disable iff (!presetn)
		!op_mode |=> !tstamp_fifo_update_flag;
	endproperty
	a_upd_mode_clr: assert property (p_upd_mode_clr) else $error("update flag kept");

	property p_upd_release;
		@(posedge pclk) disable iff (!presetn)
		(tstamp_fifo_release && !upd_set) |=> !tstamp_fifo_update_flag;
	endproperty
	a_upd_release: assert property (p_upd_release) else $error("release ignored");

	property p_upd_set;
		@(posedge pclk) disable iff (!presetn)
		(upd_set && op_mode) |=> tstamp_fifo_update_flag;
	endproperty
	a_upd_set: assert property (p_upd_set) else $error("update flag not set");

	property p_write_one_ignored;
		@(posedge pclk) disable iff (!presetn)
		(wr_flags && !tstamp_fifo_update_flag && !upd_set) |=> !tstamp_fifo_update_flag;
	endproperty
	a_write_one_ignored: assert property (p_write_one_ignored)
		else $error("write set a flag");

	property p_fs_set;
		@(posedge pclk) disable iff (!presetn)
		(tx_done.done && tx_done.queue == 2'd2 && !leave_op) |=> frame_sent_flag[2];
	endproperty
	a_fs_set: assert property (p_fs_set) else $error("queue flag not set");

	property p_fs_leave;
		@(posedge pclk) disable iff (!presetn)
		leave_op |=> (frame_sent_flag == '0);
	endproperty
	a_fs_leave: assert property (p_fs_leave) else $error("queue flags kept");

	property p_fs_sw_only_zero;
		@(posedge pclk) disable iff (!presetn)
		(wr_flags && !frame_sent_flag[0] && !fs_set[0]) |=> !frame_sent_flag[0];
	endproperty
	a_fs_sw_only_zero: assert property (p_fs_sw_only_zero)
		else $error("write set queue flag");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(|(frame_sent_flag & tx_irq_enables[TIF_NUM_Q-1:0])) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_rsv_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr == TIF_OFF_FLAGS) |-> (prdata & ~TIF_FLAG_MASK) == '0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");

	property p_desc_sum;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && paddr == TIF_OFF_SUMMARY) |->
			prdata[31:TIF_SUM_DESC_LO] == $past(desc_sum[15:1]) && !prdata[16];
	endproperty
	a_desc_sum: assert property (p_desc_sum) else $error("summary mismatch");
endmodule : tif_top

// file: bench/tif_top_tb.sv
// Purpose: Self-checking bench for transmit flags, summary and interrupt
// Assumes: One pclk domain, APB answer after one wait state
// Notes: Summary sources come from a fixed-seed shift register
`timescale 1ns/1ps
module tif_top_tb;
	import tif_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, op_mode, fen, frel, held;
	logic pready, pslverr, irq, rxe, rxf, mac, ptp, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, ef, ee, seed, fl, en;
	tif_txdone_s txd;
	tif_desc_s dsc;
	int n_mismatch, n_checks, cyc;

	tif_top u_tif_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_mode(op_mode), .tstamp_fifo_enable(fen),
		.tstamp_fifo_release(frel), .tstamp_fifo_one_held(held), .tx_done(txd),
		.desc_irq(dsc), .rx_fifo_warn_enable(rxe), .rx_fifo_warn_flag(rxf), .mac_irq(mac),
		.ptp_irq_summary(ptp), .error_flag_reg(ef), .error_enable_reg(ee), .irq(irq));

	// Clock at 50 MHz
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rdchk

	// One finished frame pulse
	task automatic frame(input logic [1:0] q, input logic ts);
		@(posedge pclk);
		txd <= '{done: 1'b1, queue: q, tstamp_req: ts};
		@(posedge pclk);
		txd.done <= 1'b0;
	endtask : frame

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int k = 0; k < 32; k++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction : lfsr

	// Expected summary word from the bench's own sources
	function automatic logic [31:0] exp_sum();
		logic [31:0] s;
		s = 32'h0;
		s[31:17] = dsc.enable[15:1] & dsc.flag[15:1];
		s[TIF_SUM_PTP] = ptp;
		s[TIF_SUM_RXWARN] = rxe & rxf;
		s[TIF_SUM_WARN] = en[TIF_BIT_WARN] & fl[TIF_BIT_WARN];
		s[TIF_SUM_UPD] = en[TIF_BIT_UPD] & fl[TIF_BIT_UPD];
		s[TIF_SUM_MAC] = mac;
		s[TIF_SUM_ERR] = |(ef & ee);
		return s;
	endfunction : exp_sum

	// Cuts a hang short
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, op_mode, fen, frel, held} = 8'h00;
		{rxe, rxf, mac, ptp} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		txd = '0;
		dsc = '0;
		ef = 32'h0;
		ee = 32'h0;
		seed = 32'h7b20;
		en = 32'h0;
		n_mismatch = 0;
		n_checks = 0;
		cyc = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("flags", TIF_OFF_FLAGS, TIF_RESET_WORD);
		rdchk("summary", TIF_OFF_SUMMARY, 32'h0);
		// Frames on every queue, stamped on queues 1 and 3
		op_mode <= 1'b1;
		fen <= 1'b1;
		held <= 1'b1;
		for (int q = 0; q < TIF_NUM_Q; q++)
			frame(q[1:0], q[0]);
		fl = 32'h30f;
		rdchk("flags", TIF_OFF_FLAGS, fl);
		rdchk("events", TIF_OFF_EVT_STATUS, fl);
		apb(1'b1, TIF_OFF_FLAGS, 32'hffff_ffff);
		rdchk("flags", TIF_OFF_FLAGS, fl);
		apb(1'b1, TIF_OFF_FLAGS, 32'hffff_fffe);
		fl = 32'h30e;
		rdchk("flags", TIF_OFF_FLAGS, fl);
		// Release pulse drops the update flag
		frel <= 1'b1;
		@(posedge pclk);
		frel <= 1'b0;
		fl = 32'h20e;
		rdchk("flags", TIF_OFF_FLAGS, fl);
		en = 32'h30f;
		apb(1'b1, TIF_OFF_ENABLES, en);
		rdchk("enables", TIF_OFF_ENABLES, en);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h1);
		// Random summary sources, first pass with errors masked
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			dsc <= {seed[15:0], seed[31:16]};
			{rxe, rxf, mac, ptp} <= seed[7:4];
			seed = lfsr(seed);
			ef <= seed;
			seed = lfsr(seed);
			ee <= (i == 0) ? 32'h0 : seed;
			apb(1'b1, TIF_OFF_SUMMARY, seed);
			rdchk("summary", TIF_OFF_SUMMARY, exp_sum());
		end
		rdchk("flags", TIF_OFF_FLAGS, fl);
		fen <= 1'b0;
		fl = 32'h00e;
		rdchk("flags", TIF_OFF_FLAGS, fl);
		// Mask, unmask, clear events
		apb(1'b1, TIF_OFF_ENABLES, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h0);
		apb(1'b1, TIF_OFF_ENABLES, en);
		apb(1'b1, TIF_OFF_EVT_CLEAR, 32'hffff_ffff);
		rdchk("events", TIF_OFF_EVT_STATUS, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h1);
		op_mode <= 1'b0;
		rdchk("flags", TIF_OFF_FLAGS, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h0);
		// Unmapped word answers with an error
		apb(1'b0, 8'h14, 32'h0);
		chk("pslverr", {31'h0, er}, 32'h1);
		chk("rdata", rd, 32'h0);
		stop_test();
	end
endmodule : tif_top_tb
